// >>> rtl/apss_map.svh
// Constants of the power-state sequencer: timing counts and reset values.
// Assumes a 100 MHz standby clock.
`ifndef APSS_MAP_SVH
`define APSS_MAP_SVH

`define APSS_CLK_MHZ         100
`define APSS_BTN_MIN_MS      50
`define APSS_BTN_OVR_MS      4000
`define APSS_BTN_MIN_CYC     (`APSS_BTN_MIN_MS * 1000 * `APSS_CLK_MHZ)
`define APSS_BTN_OVR_CYC     (`APSS_BTN_OVR_MS * 1000 * `APSS_CLK_MHZ)
`define APSS_WARN_MS         1
`define APSS_WARN_CYC        (`APSS_WARN_MS * 1000 * `APSS_CLK_MHZ)
`define APSS_CNT_W           32
`define APSS_SYNC_STAGES     2
`define APSS_SYNC_W          8
`define APSS_SYNC_RST        8'hff

`endif

// >>> rtl/apss_pkg.sv
// Types of the power-state sequencer.
// Shared by the sequencer and its synchroniser.
package apss_pkg;

    typedef enum logic [2:0] {
        APSS_G3      = 3'b000,
        APSS_S5      = 3'b001,
        APSS_S5_TO_0 = 3'b010,
        APSS_S0      = 3'b011,
        APSS_WARN    = 3'b100,
        APSS_S3      = 3'b101,
        APSS_S4      = 3'b110
    } apss_state_t;

    typedef enum logic [1:0] {
        APSS_SLP_S3  = 2'b00,
        APSS_SLP_S4  = 2'b01,
        APSS_SLP_S5  = 2'b10
    } apss_sleep_t;

endpackage

// >>> rtl/apss_sync.sv
// Two-stage synchroniser for a group of asynchronous input levels.
// Assumes all inputs are idle high; reset value is the idle level.
`timescale 1ns/1ps
`include "apss_map.svh"

module apss_sync
    import apss_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic [`APSS_SYNC_W-1:0]   async_in,
    output logic      [`APSS_SYNC_W-1:0]   sync_out
);

    logic [`APSS_SYNC_W-1:0] meta_r;

    // ============================================================
    // Per-bit double flop
    genvar i;
    generate
        for (i = 0; i < `APSS_SYNC_W; i = i + 1) begin : g_bit
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    meta_r[i]   <= 1'b1;
                    sync_out[i] <= 1'b1;
                end else begin
                    meta_r[i]   <= async_in[i];
                    sync_out[i] <= meta_r[i];
                end
            end
        end
    endgenerate

endmodule

// >>> rtl/apss_seq.sv
// Power-state sequencer: tracks G3/S5/S3/S4/S0 and drives status pins.
// Assumes reset comes from standby power-up and clk is the 100 MHz standby clock.
// Behaviour
// - Suspend warning goes low before any suspend is entered.
// - RAM-suspend output low only in S3, and in ATX mode also from S5-to-S0 through the suspend warning.
// - Disk-suspend output low only in S4.
// - Soft-off output low only in S5.
// - Active-low PCIe wake input wakes from sleep.
// - Active-low general wake input wakes from sleep.
// - Lid switch level is reported to the operating system.
// - Sleep button sends system to sleep in ATX mode, to S5 in single mode, and wakes it.
// - ATX mode: enter S5 after standby rail, then head to S0.
// - ATX mode: RAM-suspend output doubles as supply turn-on request.
// - ATX mode: wait for supply good high before reaching S0.
// - Single mode: S5 to S0 on button, wake or main power return.
// - Single mode: S0 to S5 on button or sleep event.
// - Button event on press lasting 50 ms up to 4 s.
// - Button held four seconds forces power off from S0 or during the suspend warning.
// - No power-up while supply good is low.
`timescale 1ns/1ps
`include "apss_map.svh"

module apss_seq
    import apss_pkg::*;
#(
    parameter logic [`APSS_CNT_W-1:0] BTN_MIN_CYC = `APSS_BTN_MIN_CYC,
    parameter logic [`APSS_CNT_W-1:0] BTN_OVR_CYC = `APSS_BTN_OVR_CYC,
    parameter logic [`APSS_CNT_W-1:0] WARN_CYC    = `APSS_WARN_CYC
)
(
    input  wire logic   clk,
    input  wire logic   reset,
    input  wire logic   atx_mode,
    input  wire logic   standby_rail,
    input  wire logic   main_power,
    input  wire logic   supply_good,
    input  wire logic   power_button_n,
    input  wire logic   sleep_button_n,
    input  wire logic   lid_switch_n,
    input  wire logic   pcie_wake_in_n,
    input  wire logic   general_wake_in_n,
    input  wire logic   os_sleep_req,
    input  wire logic   os_sleep_type_s4,
    output logic        suspend_warning_n,
    output logic        ram_suspend_state_n,
    output logic        disk_suspend_state_n,
    output logic        soft_off_state_n,
    output logic        lid_closed,
    output logic        power_button_event,
    output logic        sleep_button_event,
    output logic        wake_event,
    output logic        system_on
);

    logic [`APSS_SYNC_W-1:0] raw_in;
    logic [`APSS_SYNC_W-1:0] syn_in;
    logic                    pbtn_s;
    logic                    sbtn_s;
    logic                    lid_s;
    logic                    pwake_s;
    logic                    gwake_s;
    logic                    stby_s;
    logic                    main_s;
    logic                    good_s;
    logic                    sbtn_d_r;
    logic                    main_d_r;
    logic                    from_g3_r;
    logic [`APSS_CNT_W-1:0]  btn_cnt_r;
    logic                    btn_ovr_r;
    logic                    pbtn_d_r;
    logic                    pbtn_evt;
    logic                    sbtn_evt;
    logic                    wake_evt;
    logic                    main_ret;
    logic [`APSS_CNT_W-1:0]  warn_cnt_r;
    apss_sleep_t             target_r;
    apss_state_t             state_r;
    apss_state_t             state_nxt;

    // ============================================================
    // Input synchronisation
    assign raw_in = {main_power, standby_rail, supply_good, general_wake_in_n,
                     pcie_wake_in_n, lid_switch_n, sleep_button_n, power_button_n};

    apss_sync u_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (raw_in),
        .sync_out (syn_in)
    );

    assign pbtn_s  = syn_in[0];
    assign sbtn_s  = syn_in[1];
    assign lid_s   = syn_in[2];
    assign pwake_s = syn_in[3];
    assign gwake_s = syn_in[4];
    assign good_s  = syn_in[5];
    assign stby_s  = syn_in[6];
    assign main_s  = syn_in[7];

    // ============================================================
    // Power button timing
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            btn_cnt_r <= '0;
            pbtn_d_r  <= 1'b1;
            btn_ovr_r <= 1'b0;
        end else begin
            pbtn_d_r <= pbtn_s;
            if (!pbtn_s) begin
                if (btn_cnt_r != BTN_OVR_CYC) begin
                    btn_cnt_r <= btn_cnt_r + 32'h0000_0001;
                end
                btn_ovr_r <= (btn_cnt_r == BTN_OVR_CYC - 32'h0000_0001);
            end else begin
                btn_cnt_r <= '0;
                btn_ovr_r <= 1'b0;
            end
        end
    end

    // Event on release after a press of 50 ms up to under 4 s
    assign pbtn_evt = pbtn_s && !pbtn_d_r && (btn_cnt_r >= BTN_MIN_CYC)
                      && (btn_cnt_r < BTN_OVR_CYC);

    // ============================================================
    // Other edge events
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sbtn_d_r  <= 1'b1;
            main_d_r  <= 1'b1;
            from_g3_r <= 1'b0;
        end else begin
            sbtn_d_r  <= sbtn_s;
            main_d_r  <= main_s;
            from_g3_r <= (state_r == APSS_G3);
        end
    end

    assign sbtn_evt = !sbtn_s && sbtn_d_r;
    assign wake_evt = !pwake_s || !gwake_s || sbtn_evt;
    assign main_ret = main_s && !main_d_r;

    // ============================================================
    // Sleep target latch and warning timer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            target_r <= APSS_SLP_S5;
        end else if (state_r == APSS_S0) begin
            if (pbtn_evt || (sbtn_evt && !atx_mode)) begin
                target_r <= APSS_SLP_S5;
            end else if (sbtn_evt || os_sleep_req) begin
                target_r <= os_sleep_type_s4 ? APSS_SLP_S4 : APSS_SLP_S3;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            warn_cnt_r <= '0;
        end else if (state_r == APSS_WARN) begin
            warn_cnt_r <= warn_cnt_r + 32'h0000_0001;
        end else begin
            warn_cnt_r <= '0;
        end
    end

    // ============================================================
    // State machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            APSS_G3: begin
                if (atx_mode && stby_s) begin
                    state_nxt = APSS_S5;
                end else if (!atx_mode && main_s) begin
                    state_nxt = APSS_S5_TO_0;
                end
            end
            APSS_S5: begin
                if (atx_mode && !stby_s) begin
                    state_nxt = APSS_G3;
                end else if (atx_mode && from_g3_r) begin
                    state_nxt = APSS_S5_TO_0;
                end else if (atx_mode && (pbtn_evt || wake_evt)) begin
                    state_nxt = APSS_S5_TO_0;
                end else if (pbtn_evt || wake_evt || main_ret) begin
                    state_nxt = APSS_S5_TO_0;
                end
            end
            APSS_S5_TO_0: begin
                if (good_s) begin
                    state_nxt = APSS_S0;
                end
            end
            APSS_S0: begin
                if (btn_ovr_r) begin
                    state_nxt = APSS_S5;
                end else if (pbtn_evt || sbtn_evt || os_sleep_req) begin
                    state_nxt = APSS_WARN;
                end
            end
            APSS_WARN: begin
                if (btn_ovr_r) begin
                    state_nxt = APSS_S5;
                end else if (warn_cnt_r >= WARN_CYC - 32'h0000_0001) begin
                    case (target_r)
                        APSS_SLP_S3: state_nxt = APSS_S3;
                        APSS_SLP_S4: state_nxt = APSS_S4;
                        default:     state_nxt = APSS_S5;
                    endcase
                end
            end
            APSS_S3, APSS_S4: begin
                if (wake_evt || pbtn_evt) begin
                    state_nxt = APSS_S5_TO_0;
                end
            end
            default: begin
                state_nxt = APSS_G3;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= APSS_G3;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ============================================================
    // Status outputs, all registered
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            suspend_warning_n    <= 1'b1;
            ram_suspend_state_n  <= 1'b1;
            disk_suspend_state_n <= 1'b1;
            soft_off_state_n     <= 1'b1;
            system_on            <= 1'b0;
        end else begin
            suspend_warning_n    <= !(state_nxt == APSS_WARN || state_nxt == APSS_S3
                                      || state_nxt == APSS_S4);
            // Low in S3, and in ATX mode low also as supply turn-on request
            ram_suspend_state_n  <= !(state_nxt == APSS_S3
                                      || (atx_mode && (state_nxt == APSS_S5_TO_0
                                      || state_nxt == APSS_S0
                                      || state_nxt == APSS_WARN)));
            disk_suspend_state_n <= !(state_nxt == APSS_S4);
            soft_off_state_n     <= !(state_nxt == APSS_S5);
            system_on            <= (state_nxt == APSS_S0);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lid_closed         <= 1'b0;
            power_button_event <= 1'b0;
            sleep_button_event <= 1'b0;
            wake_event         <= 1'b0;
        end else begin
            lid_closed         <= !lid_s;
            power_button_event <= pbtn_evt;
            sleep_button_event <= sbtn_evt;
            wake_event         <= !pwake_s || !gwake_s;
        end
    end

endmodule

// >>> tb/apss_seq_asserts.sv
// Port assertions of the power-state sequencer.
// Assumes binding into apss_seq; counts follow its parameters.
`timescale 1ns/1ps

module apss_seq_chk #(
    parameter logic [31:0] BTN_OVR_CYC = 32'h28
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic atx_mode,
    input wire logic supply_good,
    input wire logic power_button_n,
    input wire logic lid_switch_n,
    input wire logic pcie_wake_in_n,
    input wire logic general_wake_in_n,
    input wire logic suspend_warning_n,
    input wire logic ram_suspend_state_n,
    input wire logic disk_suspend_state_n,
    input wire logic soft_off_state_n,
    input wire logic lid_closed,
    input wire logic power_button_event,
    input wire logic wake_event,
    input wire logic system_on
);
    // ==========
    // Helpers
    logic [31:0] low_cnt_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    always_ff @(posedge clk or posedge reset) begin
        if (reset || power_button_n) low_cnt_r <= 32'h0;
        else low_cnt_r <= low_cnt_r + 32'h1;
    end
    sequence lid_low; !lid_switch_n [*4]; endsequence
    sequence lid_high; lid_switch_n [*4]; endsequence
    sequence wake_low; (!pcie_wake_in_n || !general_wake_in_n) [*4]; endsequence
    sequence wake_idle; (pcie_wake_in_n && general_wake_in_n) [*4]; endsequence
    // ==========
    // Assertions
    lid_level_a: assert property ((lid_low |-> lid_closed) and (lid_high |-> !lid_closed))
        else $error("lid level wrong");
    wake_level_a: assert property ((wake_low |-> wake_event) and (wake_idle |-> !wake_event))
        else $error("wake level wrong");
    ram_state_a: assert property (!atx_mode |-> ram_suspend_state_n || !suspend_warning_n && !system_on)
        else $error("ram state wrong");
    disk_state_a: assert property (!disk_suspend_state_n |-> !suspend_warning_n && !system_on && soft_off_state_n)
        else $error("disk state wrong");
    soft_off_a: assert property (!soft_off_state_n |-> suspend_warning_n && !system_on && disk_suspend_state_n)
        else $error("soft off wrong");
    warn_first_a: assert property ($fell(disk_suspend_state_n) |-> !$past(suspend_warning_n))
        else $error("no warning before suspend");
    turn_on_a: assert property (atx_mode |-> (soft_off_state_n || ram_suspend_state_n) && (!system_on || !ram_suspend_state_n))
        else $error("turn-on request wrong");
    good_gate_a: assert property ($rose(system_on) |-> $past(supply_good, 3))
        else $error("on without supply good");
    btn_pulse_a: assert property (power_button_event |-> power_button_n ##1 !power_button_event)
        else $error("button event wrong");
    ovr_off_a: assert property (low_cnt_r == BTN_OVR_CYC + 32'h4 |-> !system_on)
        else $error("override ignored");
endmodule

bind apss_seq apss_seq_chk #(.BTN_OVR_CYC(BTN_OVR_CYC)) u_chk (.*);

// >>> tb/apss_carrier.sv
// Carrier supply model: answers the turn-on request with supply good.
// Assumes the sequencer clock and reset.
`timescale 1ns/1ps

module apss_carrier #(
    parameter int DLY = 6
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic atx_mode,
    input  wire logic supply_turn_on_n,
    input  wire logic hold_off,
    output logic      supply_good
);
    int cnt_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset || supply_turn_on_n || hold_off) cnt_r <= 0;
        else if (cnt_r < DLY) cnt_r <= cnt_r + 1;
    end
    assign supply_good = atx_mode ? (cnt_r == DLY) : 1'b1;
endmodule

// >>> tb/acpi_power_state_sequencer_test.sv
// Self-checking bench of the power-state sequencer.
// Assumes the carrier model and the bound checker are compiled with it.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end

module acpi_power_state_sequencer_test;
    logic clk = 1'b0, reset = 1'b1, atx_mode = 1'b0, hold_off = 1'b0;
    logic standby_rail = 1'b1, main_power = 1'b1, supply_good;
    logic power_button_n = 1'b1, sleep_button_n = 1'b1, lid_switch_n = 1'b1;
    logic pcie_wake_in_n = 1'b1, general_wake_in_n = 1'b1;
    logic os_sleep_req = 1'b0, os_sleep_type_s4 = 1'b0;
    logic suspend_warning_n, ram_suspend_state_n, disk_suspend_state_n;
    logic soft_off_state_n, lid_closed, power_button_event;
    logic sleep_button_event, wake_event, system_on, wseen, oseen;
    int   err_count = 0, checks = 0, pev = 0, sev = 0;
    wire [4:0] st = {system_on, suspend_warning_n, ram_suspend_state_n,
                     disk_suspend_state_n, soft_off_state_n};

    apss_seq #(.BTN_MIN_CYC(32'h5), .BTN_OVR_CYC(32'h28), .WARN_CYC(32'h3)) DUT (.*);
    apss_carrier #(.DLY(6)) u_psu (.clk(clk), .reset(reset), .atx_mode(atx_mode),
        .supply_turn_on_n(ram_suspend_state_n), .hold_off(hold_off),
        .supply_good(supply_good));

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (power_button_event === 1'b1) pev++;
        if (sleep_button_event === 1'b1) sev++;
        if (suspend_warning_n === 1'b0) wseen = 1'b1;
        if (soft_off_state_n === 1'b0) oseen = 1'b1;
    end

    // ==========
    // Helpers
    task automatic give_verdict;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wait_st(input logic [4:0] exp);
        for (int i = 0; i < 300 && st !== exp; i++) @(negedge clk);
        `CHK(st, exp)
    endtask
    task automatic hold(input bit slp, input int n);
        @(negedge clk);
        pev = 0;
        if (slp) sleep_button_n = 1'b0;
        else power_button_n = 1'b0;
        repeat (n) @(negedge clk);
        power_button_n = 1'b1;
        sleep_button_n = 1'b1;
    endtask
    task automatic wake_by(input bit gen, input logic [4:0] exp);
        if (gen) general_wake_in_n = 1'b0;
        else pcie_wake_in_n = 1'b0;
        wait_st(exp);
        pcie_wake_in_n = 1'b1;
        general_wake_in_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    task automatic rst(input logic atx);
        reset = 1'b1;
        atx_mode = atx;
        oseen = 1'b0;
        repeat (8) @(negedge clk);
        reset = 1'b0;
    endtask

    // ==========
    // Scenarios
    task automatic t_btn;
        wait_st(5'h1f);
        wseen = 1'b0;
        fork hold(0, 10); join
        wait_st(5'h0e);
        `CHK(wseen, 1'b1)
        hold(0, 3);
        repeat (10) @(negedge clk);
        `CHK(st, 5'h0e)
        `CHK(pev, 0)
    endtask
    task automatic t_press_len;
        pev = 0;
        power_button_n = 1'b0;
        repeat (10) @(negedge clk);
        power_button_n = 1'b1;
        wait_st(5'h1f);
        `CHK(pev, 1)
    endtask
    task automatic t_sleep_wake;
        sev = 0;
        hold(1, 10);
        wait_st(5'h0e);
        `CHK(sev, 1)
        wake_by(1, 5'h1f);
        hold(0, 60);
        wait_st(5'h0e);
        `CHK(pev, 0)
        wake_by(0, 5'h1f);
    endtask
    task automatic t_main_lid;
        hold(1, 10);
        wait_st(5'h0e);
        main_power = 1'b0;
        repeat (10) @(negedge clk);
        main_power = 1'b1;
        wait_st(5'h1f);
        lid_switch_n = 1'b0;
        repeat (6) @(negedge clk);
        `CHK(lid_closed, 1'b1)
        lid_switch_n = 1'b1;
        repeat (6) @(negedge clk);
        `CHK(lid_closed, 1'b0)
    endtask
    task automatic t_atx;
        hold_off = 1'b1;
        rst(1'b1);
        wait_st(5'h0b);
        repeat (60) @(negedge clk);
        `CHK(st, 5'h0b)
        `CHK(oseen, 1'b1)
        hold_off = 1'b0;
        wait_st(5'h1b);
        os_sleep_type_s4 = 1'b1;
        hold(1, 10);
        wait_st(5'h05);
        wake_by(1, 5'h1b);
        os_sleep_type_s4 = 1'b0;
        os_sleep_req = 1'b1;
        @(negedge clk);
        os_sleep_req = 1'b0;
        wait_st(5'h03);
        wake_by(0, 5'h1b);
        hold(0, 60);
        repeat (20) @(negedge clk);
        `CHK(st, 5'h0e)
        wake_by(0, 5'h1b);
    endtask

    initial begin
        rst(1'b0);
        t_btn();
        t_press_len();
        t_sleep_wake();
        t_main_lid();
        t_atx();
        give_verdict();
    end
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
endmodule
